// [verif/ddcs_properties.sv]
// Port checker for the clock setup block.
// Assumes one clock and a synchronous active-high reset; bound below.
module ddcs_props #(parameter int SHUTDOWN_CNT = 20) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic main_functions_active_i,
    input wire logic [1:0] main_source_select_o,
    input wire logic main_clock_enable_o,
    input wire logic [2:0] main_core_div_o,
    input wire logic main_shutdown_done_o,
    input wire logic shutdown_event_o,
    input wire logic gpio_status_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    logic [7:0] idle_q, idle_d;
    logic wr;
    assign wr = psel_i && penable_i && pwrite_i;
    // Cycles with the domain stopped; wrap only loosens the check
    always_comb begin
        idle_d = (main_clock_enable_o || main_functions_active_i) ? 8'h00 : idle_q + 8'h01;
    end
    always_ff @(posedge ref_clk_i) begin
        idle_q <= rst_i ? 8'h00 : idle_d;
    end
    sequence s_stop;
        !main_clock_enable_o && !main_functions_active_i;
    endsequence
    a_src_legal: assert property (main_source_select_o != 2'h3)
        else $error("source code out of range");
    a_div_follows: assert property ($changed(main_core_div_o) && !$past(rst_i, 2) |->
        $past(wr, 2)) else $error("divider moved without a write");
    a_core_bounded: assert property (main_core_div_o != 3'h7)
        else $error("core divider above top code");
    a_done_wait: assert property ($rose(main_shutdown_done_o) |->
        s_stop and (idle_q >= 8'(SHUTDOWN_CNT - 1))) else $error("done rose too early");
    a_done_settles: assert property (idle_q >= 8'(SHUTDOWN_CNT + 3) |-> main_shutdown_done_o)
        else $error("done missing after stop");
    a_done_clear: assert property (main_clock_enable_o |=> !main_shutdown_done_o)
        else $error("done kept while enabled");
    a_event_rise: assert property ($rose(main_shutdown_done_o) |-> shutdown_event_o)
        else $error("no event on done");
    a_event_once: assert property (shutdown_event_o |->
        $rose(main_shutdown_done_o) ##1 !shutdown_event_o) else $error("stray event");
    a_gpio_status: assert property (gpio_status_o |-> main_shutdown_done_o)
        else $error("pin shows done wrongly");
endmodule : ddcs_props
bind dual_domain_clock_setup ddcs_props #(.SHUTDOWN_CNT(SHUTDOWN_CNT)) u_props (.ref_clk_i,
    .rst_i, .psel_i, .penable_i, .pwrite_i, .main_functions_active_i, .main_source_select_o,
    .main_clock_enable_o, .main_core_div_o, .main_shutdown_done_o, .shutdown_event_o,
    .gpio_status_o);

// [verif/domain_funcs.sv]
// Model of one domain's functions: they run while the clock is enabled.
// Assumes the enable comes from the block; winding down takes LINGER cycles.
module domain_funcs #(parameter int LINGER = 5) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ena_i,
    output logic active_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_q, cnt_d;
    always_comb begin
        cnt_d = ena_i ? 8'(LINGER) : (cnt_q != 8'h00 ? cnt_q - 8'h01 : cnt_q);
    end
    always_ff @(posedge ref_clk_i) begin
        cnt_q <= rst_i ? 8'h00 : cnt_d;
    end
    assign active_o = cnt_q != 8'h00;
endmodule : domain_funcs

// [verif/dual_domain_clock_setup_tb.sv]
// Self-checking bench for the clock setup block.
// Assumes a zero-wait APB slave and the domain function model.
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module dual_domain_clock_setup_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LINGER = 5;
    localparam int SHUT = 2;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, ev, gpio;
    logic m_act, s_act, m_en, s_en, m_done, s_done;
    logic [1:0] m_src, s_src;
    logic [2:0] m_div, s_div;
    logic [7:0] c_div;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, seed, cfg;
    logic [32:0] e_m;
    logic [32:0] exp_q[$];
    int err_count, n_compared, t, ev_count;
    dual_domain_clock_setup #(.SHUTDOWN_CNT(SHUT)) DUT (.ref_clk_i(clk), .rst_i(rst),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .main_functions_active_i(m_act), .sec_functions_active_i(s_act),
        .main_source_select_o(m_src), .sec_source_select_o(s_src), .main_clock_enable_o(m_en),
        .sec_clock_enable_o(s_en), .main_core_div_o(m_div), .sec_core_div_o(s_div),
        .conv_rate_div_o(c_div), .main_shutdown_done_o(m_done), .sec_shutdown_done_o(s_done),
        .shutdown_event_o(ev), .gpio_status_o(gpio));
    domain_funcs #(.LINGER(LINGER)) u_mf (.ref_clk_i(clk), .rst_i(rst), .ena_i(m_en),
        .active_o(m_act));
    domain_funcs #(.LINGER(LINGER)) u_sf (.ref_clk_i(clk), .rst_i(rst), .ena_i(s_en),
        .active_o(s_act));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
        input logic [32:0] e);
        @(posedge clk);
        {psel, penable, paddr, pwrite, pwdata} <= {2'b10, a, w, d};
        if (!w) exp_q.push_back(e);
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude
    always @(posedge clk) begin
        if (ev === 1'b1) ev_count <= ev_count + 1;
        if (psel && penable && !pwrite && pready) begin
            e_m = exp_q.pop_front();
            `CHK("read", e_m, {pslverr, prdata})
        end
    end
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        conclude();
    end
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 8'h00, 32'h0};
        seed = 32'h0001_79A8;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        apb(8'h00, 0, 0, 33'h0_0000_0500);
        apb(8'h04, 0, 0, 33'h0_0000_0300);
        apb(8'h08, 0, 0, 33'h0_0003_0303);
        apb(8'h0C, 0, 0, 33'h0_0000_0003);
        apb(8'h20, 0, 0, 33'h1_0000_0000);
        for (int k = 0; k < 3; k++) begin
            seed = xs(seed);
            // any listed code of either family
            cfg = 32'h0001_0001 | (32'(k) << 4) | ((seed % 7) << 8) | (32'(seed[31]) << 15);
            apb(8'h00, 1, cfg, 0);
            apb(8'h00, 0, 0, {1'b0, cfg});
            repeat (2) @(posedge clk);
            `CHK("div", cfg[10:8], m_div)
            `CHK("src", 2'(k), m_src)
            `CHK("done", 1'b0, m_done)
            `CHK("gpio", 1'b0, gpio)
        end
        // reserved frequency and unused source refused
        apb(8'h00, 1, cfg | 32'h0000_0730, 0);
        apb(8'h00, 0, 0, {1'b0, cfg});
        // secondary domain in one rate family
        apb(8'h04, 1, 32'h0000_0721, 0);
        apb(8'h04, 1, 32'h0000_0731, 0);
        apb(8'h04, 0, 0, 33'h0_0000_0321);
        `CHK("sec", 3'h6, {s_en, s_src})
        `CHK("sec_div", 3'h3, s_div)
        apb(8'h08, 1, 32'h0013_1105, 0);
        apb(8'h08, 0, 0, 33'h0_0013_1105);
        `CHK("conv", 8'h02 << cfg[9:8], c_div)
        apb(8'h0C, 1, 32'h0000_0003, 0);
        apb(8'h0C, 0, 0, 33'h0);
        apb(8'h00, 1, cfg & ~32'h1, 0);
        t = 0;
        while (m_done !== 1'b1 && t < 200) begin
            @(posedge clk);
            t++;
        end
        `CHK("wait", LINGER + SHUT + 1, t)
        `CHK("event", 1'b1, ev)
        `CHK("gpio", 1'b1, gpio)
        apb(8'h0C, 0, 0, 33'h0_0000_0001);
        apb(8'h00, 1, cfg, 0);
        repeat (2) @(posedge clk);
        `CHK("done", 1'b0, m_done)
        apb(8'h04, 1, 32'h0000_0320, 0);
        t = 0;
        while (s_done !== 1'b1 && t < 200) begin
            @(posedge clk);
            t++;
        end
        `CHK("sec_wait", LINGER + SHUT + 1, t)
        `CHK("events", 1, ev_count)
        conclude();
    end
endmodule : dual_domain_clock_setup_tb

// [verilog/clk_setup_pkg.sv]
// Constants for the dual-domain clock setup block: register map, fields, resets.
// Assumes a 32-bit APB master and a single 20 MHz reference clock.
package clk_setup_pkg;
    localparam logic [7:0] MAIN_CFG_ADDR = 8'h00;
    localparam logic [7:0] SEC_CFG_ADDR = 8'h04;
    localparam logic [7:0] RATE_ADDR = 8'h08;
    localparam logic [7:0] STATUS_ADDR = 8'h0C;
    localparam logic [7:0] DIV_ADDR = 8'h10;
    // Main and secondary config fields
    localparam int MAIN_ENA_BIT = 0;
    localparam int MAIN_SRC_LSB = 4;
    localparam int MAIN_FREQ_LSB = 8;
    localparam int MAIN_FAM_BIT = 15;
    localparam int SEC_ENA_BIT = 0;
    localparam int SEC_SRC_LSB = 4;
    localparam int SEC_FREQ_LSB = 8;
    localparam int GPIO_ROUTE_BIT = 16;
    localparam logic [31:0] MAIN_CFG_RESET = 32'h0000_0500;
    localparam logic [31:0] SEC_CFG_RESET = 32'h0000_0300;
    localparam logic [31:0] RATE_RESET = 32'h0003_0303;
    localparam logic [2:0] FREQ_RESERVED = 3'h7;
    // Cycles to wait after the domain functions go inactive once enable is cleared
    localparam int SHUTDOWN_NS = 1000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int SHUTDOWN_CYCLES = (SHUTDOWN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Clock source selector codes
    typedef enum logic [1:0] {
        SRC_MASTER_CLK = 2'h0,
        SRC_BIT_CLK = 2'h1,
        SRC_LOOP = 2'h2
    } clk_src_t;
endpackage : clk_setup_pkg

// [verilog/dual_domain_clock_setup.sv]
// Clock domain setup: source select, frequency/rate coding, divider derivation,
// enable/shutdown handshake. Assumes an APB master with 32-bit data.
//
// The register addresses and the APB slave port were chosen for this implementation.
module dual_domain_clock_setup
    import clk_setup_pkg::*;
#(
    parameter int SHUTDOWN_CNT = SHUTDOWN_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic main_functions_active_i,
    input wire logic sec_functions_active_i,
    output logic [1:0] main_source_select_o,
    output logic [1:0] sec_source_select_o,
    output logic main_clock_enable_o,
    output logic sec_clock_enable_o,
    output logic [2:0] main_core_div_o,
    output logic [2:0] sec_core_div_o,
    output logic [7:0] conv_rate_div_o,
    output logic main_shutdown_done_o,
    output logic sec_shutdown_done_o,
    output logic shutdown_event_o,
    output logic gpio_status_o
);
    logic [31:0] main_cfg_q, main_cfg_d;
    logic [31:0] sec_cfg_q, sec_cfg_d;
    logic [31:0] rate_q, rate_d;
    logic main_done_q, main_done_d;
    logic sec_done_q, sec_done_d;
    logic [15:0] main_cnt_q, main_cnt_d;
    logic [15:0] sec_cnt_q, sec_cnt_d;
    logic event_q, event_d;
    logic [31:0] rdata_q, rdata_d;
    logic [2:0] main_div_q, main_div_d;
    logic [2:0] sec_div_q, sec_div_d;
    logic [7:0] conv_div_q, conv_div_d;
    logic wr_en;
    logic rd_en;
    logic addr_ok;

    // Base divider ratio for a rate code: frequency needed relative to 6.144/5.6448 MHz base
    function automatic logic [7:0] rate_ratio(input logic [7:0] code);
        unique case (code)
            8'h01, 8'h09: rate_ratio = 8'h20;
            8'h02, 8'h0A: rate_ratio = 8'h10;
            8'h03, 8'h0B: rate_ratio = 8'h08;
            8'h04, 8'h0C: rate_ratio = 8'h04;
            8'h05, 8'h0D: rate_ratio = 8'h02;
            8'h11: rate_ratio = 8'h30;
            8'h12: rate_ratio = 8'h18;
            8'h13: rate_ratio = 8'h0C;
            default: rate_ratio = 8'h00;
        endcase
    endfunction : rate_ratio

    assign addr_ok = (paddr_i == MAIN_CFG_ADDR) || (paddr_i == SEC_CFG_ADDR) ||
                     (paddr_i == RATE_ADDR) || (paddr_i == STATUS_ADDR) ||
                     (paddr_i == DIV_ADDR);
    assign wr_en = psel_i && penable_i && pwrite_i;
    assign rd_en = psel_i && !penable_i && !pwrite_i;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !addr_ok;

    always_comb begin
        main_cfg_d = main_cfg_q;
        sec_cfg_d = sec_cfg_q;
        rate_d = rate_q;
        rdata_d = rdata_q;
        if (wr_en) begin
            unique case (paddr_i)
                MAIN_CFG_ADDR: begin
                    main_cfg_d = pwdata_i;
                    if (pwdata_i[MAIN_FREQ_LSB +: 3] == FREQ_RESERVED) begin
                        main_cfg_d[MAIN_FREQ_LSB +: 3] = main_cfg_q[MAIN_FREQ_LSB +: 3];
                    end
                    // unused source code keeps the current source
                    if (pwdata_i[MAIN_SRC_LSB +: 2] == 2'h3) begin
                        main_cfg_d[MAIN_SRC_LSB +: 2] = main_cfg_q[MAIN_SRC_LSB +: 2];
                    end
                end
                SEC_CFG_ADDR: begin
                    sec_cfg_d = pwdata_i;
                    sec_cfg_d[SEC_FREQ_LSB + 2] = 1'b0;
                    // unused source code keeps the current source
                    if (pwdata_i[SEC_SRC_LSB +: 2] == 2'h3) begin
                        sec_cfg_d[SEC_SRC_LSB +: 2] = sec_cfg_q[SEC_SRC_LSB +: 2];
                    end
                end
                RATE_ADDR: rate_d = pwdata_i;
                default: ;
            endcase
        end
        if (rd_en) begin
            unique case (paddr_i)
                MAIN_CFG_ADDR: rdata_d = main_cfg_q;
                SEC_CFG_ADDR: rdata_d = sec_cfg_q;
                RATE_ADDR: rdata_d = rate_q;
                STATUS_ADDR: rdata_d = {30'h0, sec_done_q, main_done_q};
                DIV_ADDR: rdata_d = {16'h0, conv_div_q, 1'b0, sec_div_q, 1'b0, main_div_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Shutdown handshake per domain
    always_comb begin
        main_cnt_d = main_cnt_q;
        main_done_d = main_done_q;
        sec_cnt_d = sec_cnt_q;
        sec_done_d = sec_done_q;
        event_d = 1'b0;
        if (main_cfg_q[MAIN_ENA_BIT]) begin
            main_done_d = 1'b0;
            main_cnt_d = 16'h0000;
        end else if (!main_done_q) begin
            if (main_functions_active_i) begin
                main_cnt_d = 16'h0000;
            end else if (main_cnt_q >= 16'(SHUTDOWN_CNT - 1)) begin
                main_done_d = 1'b1;
                event_d = 1'b1;
            end else begin
                main_cnt_d = main_cnt_q + 16'h0001;
            end
        end
        if (sec_cfg_q[SEC_ENA_BIT]) begin
            sec_done_d = 1'b0;
            sec_cnt_d = 16'h0000;
        end else if (!sec_done_q) begin
            if (sec_functions_active_i) begin
                sec_cnt_d = 16'h0000;
            end else if (sec_cnt_q >= 16'(SHUTDOWN_CNT - 1)) begin
                sec_done_d = 1'b1;
            end else begin
                sec_cnt_d = sec_cnt_q + 16'h0001;
            end
        end
    end

    always_comb begin
        // core divider from configured frequency, never faster than it
        main_div_d = main_cfg_q[MAIN_FREQ_LSB +: 3];
        sec_div_d = sec_cfg_q[SEC_FREQ_LSB +: 3];
        // rates 8..192 kHz via rate code ratio
        conv_div_d = rate_ratio(rate_q[7:0]) << main_cfg_q[MAIN_FREQ_LSB +: 2];
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            main_cfg_q <= MAIN_CFG_RESET;
            sec_cfg_q <= SEC_CFG_RESET;
            rate_q <= RATE_RESET;
            rdata_q <= 32'h0000_0000;
            main_done_q <= 1'b1;
            sec_done_q <= 1'b1;
            main_cnt_q <= 16'h0000;
            sec_cnt_q <= 16'h0000;
            event_q <= 1'b0;
            main_div_q <= 3'h0;
            sec_div_q <= 3'h0;
            conv_div_q <= 8'h00;
        end else begin
            main_cfg_q <= main_cfg_d;
            sec_cfg_q <= sec_cfg_d;
            rate_q <= rate_d;
            rdata_q <= rdata_d;
            main_done_q <= main_done_d;
            sec_done_q <= sec_done_d;
            main_cnt_q <= main_cnt_d;
            sec_cnt_q <= sec_cnt_d;
            event_q <= event_d;
            main_div_q <= main_div_d;
            sec_div_q <= sec_div_d;
            conv_div_q <= conv_div_d;
        end
    end

    assign prdata_o = rdata_q;
    assign main_source_select_o = main_cfg_q[MAIN_SRC_LSB +: 2];
    assign sec_source_select_o = sec_cfg_q[SEC_SRC_LSB +: 2];
    assign main_clock_enable_o = main_cfg_q[MAIN_ENA_BIT];
    assign sec_clock_enable_o = sec_cfg_q[SEC_ENA_BIT];
    assign main_core_div_o = main_div_q;
    assign sec_core_div_o = sec_div_q;
    assign conv_rate_div_o = conv_div_q;
    assign main_shutdown_done_o = main_done_q;
    assign sec_shutdown_done_o = sec_done_q;
    assign shutdown_event_o = event_q;
    assign gpio_status_o = main_cfg_q[GPIO_ROUTE_BIT] & main_done_q;
endmodule : dual_domain_clock_setup
